//--- verilog/shift_bit_defs.svh
/*
 * Constants for the shift/rotate and bit-manipulation datapath.
 * Assumes inclusion by bare name from the package and from shift_bit_unit.
 */
`ifndef SHIFT_BIT_DEFS_SVH
`define SHIFT_BIT_DEFS_SVH

`define DATA_W      32
`define BYTE_W      8
`define BITNO_W     3
`define OPC_W       5
`define SIZE_W      2
`define FLAGS_RESET 1'b0

`endif

//--- verilog/shift_bit_pkg.sv
/*
 * Types for the shift/rotate and bit-manipulation datapath.
 * Assumes shift_bit_defs.svh is on the include path.
 */
`include "shift_bit_defs.svh"

package shift_bit_pkg;

    typedef enum logic [4:0] {
        arith_shift_left        = 5'h00,
        arith_shift_right       = 5'h01,
        logic_shift_left        = 5'h02,
        logic_shift_right       = 5'h03,
        rotate_left             = 5'h04,
        rotate_right            = 5'h05,
        rotate_left_thru_carry  = 5'h06,
        rotate_right_thru_carry = 5'h07,
        bit_force_one           = 5'h08,
        bit_force_zero          = 5'h09,
        bit_invert              = 5'h0a,
        bit_probe               = 5'h0b,
        carry_and_bit           = 5'h0c,
        carry_and_inv_bit       = 5'h0d,
        carry_or_bit            = 5'h0e,
        carry_or_inv_bit        = 5'h0f,
        carry_xor_bit           = 5'h10,
        carry_xor_inv_bit       = 5'h11,
        bit_to_carry            = 5'h12,
        inv_bit_to_carry        = 5'h13,
        carry_to_bit            = 5'h14,
        inv_carry_to_bit        = 5'h15
    } op_t;

    typedef enum logic [1:0] {
        size_byte = 2'h0,
        size_word = 2'h1,
        size_long = 2'h2
    } size_t;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_busy = 2'b01,
        st_done = 2'b11
    } state_t;

    // one request from the issue stage
    typedef struct packed {
        op_t                   op;
        size_t                 size;
        logic                  two_pos;
        logic                  bitno_from_reg;
        logic [`BITNO_W-1:0]   bitno_imm;
        logic [`BITNO_W-1:0]   bitno_reg;
        logic [`DATA_W-1:0]    operand;
        logic                  carry_in;
    } req_t;

    // one result back to register file / memory / flags
    typedef struct packed {
        logic [`DATA_W-1:0]    result;
        logic                  write_back;
        logic                  carry;
        logic                  carry_we;
        logic                  zero;
        logic                  zero_we;
        logic                  bad_bitno_src;
    } rsp_t;

endpackage : shift_bit_pkg

//--- verilog/shift_stage.sv
/*
 * Single-position shift/rotate stage, sized byte/word/long.
 * Assumes operand bits above the chosen size are ignored by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module shift_stage (
    input  wire logic [31:0]         din,
    input  wire logic                cin,
    input  wire shift_bit_pkg::op_t  op,
    input  wire shift_bit_pkg::size_t size,
    output logic      [31:0]         dout,
    output logic                     cout
);
    import shift_bit_pkg::*;

    wire       is_left = (op == arith_shift_left) || (op == logic_shift_left)
                      || (op == rotate_left) || (op == rotate_left_thru_carry);
    wire [5:0] msb     = (size == size_byte) ? 6'h07 :
                         (size == size_word) ? 6'h0f : 6'h1f;
    wire       top_bit = din[msb[4:0]];
    wire       low_bit = din[0];
    wire       fill_r  = (op == arith_shift_right) ? top_bit :
                         (op == rotate_right)       ? low_bit :
                         (op == rotate_right_thru_carry) ? cin : 1'b0;
    wire       fill_l  = (op == rotate_left) ? top_bit :
                         (op == rotate_left_thru_carry) ? cin : 1'b0;

    logic [31:0] right_v;
    logic [31:0] left_v;

    always_comb begin
        right_v = din >> 1;
        right_v[msb[4:0]] = fill_r;
        left_v  = {din[30:0], fill_l};
    end

    // last bit out goes to carry
    assign cout = is_left ? top_bit : low_bit;
    assign dout = is_left ? left_v : right_v;

endmodule : shift_stage

`default_nettype wire

//--- verilog/bit_unit.sv
/*
 * Byte bit-manipulation and carry-combining logic.
 * Assumes a validated bit number and the current carry flag.
 */
`timescale 1ns/1ps
`default_nettype none

module bit_unit (
    input  wire logic [7:0]          din,
    input  wire logic [2:0]          bitno,
    input  wire logic                cin,
    input  wire shift_bit_pkg::op_t  op,
    output logic      [7:0]          dout,
    output logic                     wr,
    output logic                     cout,
    output logic                     c_we,
    output logic                     zout,
    output logic                     z_we
);
    import shift_bit_pkg::*;

    wire [7:0] mask = 8'h01 << bitno;
    wire       sel  = din[bitno];

    always_comb begin
        dout = din;
        wr   = 1'b0;
        cout = cin;
        c_we = 1'b1;
        zout = 1'b0;
        z_we = 1'b0;
        unique case (op)
            bit_force_one:  begin dout = din | mask;  wr = 1'b1; c_we = 1'b0; end
            bit_force_zero: begin dout = din & ~mask; wr = 1'b1; c_we = 1'b0; end
            bit_invert:     begin dout = din ^ mask;  wr = 1'b1; c_we = 1'b0; end
            bit_probe:      begin zout = ~sel; z_we = 1'b1; c_we = 1'b0; end
            carry_and_bit:     cout = cin & sel;
            carry_and_inv_bit: cout = cin & ~sel;
            carry_or_bit:      cout = cin | sel;
            carry_or_inv_bit:  cout = cin | ~sel;
            carry_xor_bit:     cout = cin ^ sel;
            carry_xor_inv_bit: cout = cin ^ ~sel;
            bit_to_carry:      cout = sel;
            inv_bit_to_carry:  cout = ~sel;
            carry_to_bit: begin
                dout = (din & ~mask) | (cin ? mask : 8'h00);
                wr = 1'b1;
                c_we = 1'b0;
            end
            inv_carry_to_bit: begin
                dout = (din & ~mask) | (cin ? 8'h00 : mask);
                wr = 1'b1;
                c_we = 1'b0;
            end
            default: c_we = 1'b0; // shift codes land here; their outputs go unused
        endcase
    end

endmodule : bit_unit

`default_nettype wire

//--- verilog/shift_bit_unit.sv
/*
 * Shift/rotate and single-bit execution datapath, one request per start.
 * Assumes the issue stage holds req stable while start is high and that
 * results are taken on the done pulse.
 */
`timescale 1ns/1ps
`default_nettype none

`include "shift_bit_defs.svh"

// Functional notes
// - arithmetic shifts, B/W/L, one or two
// - logical shifts, B/W/L, one or two
// - plain rotates, B/W/L, one or two
// - rotates through carry, B/W/L, one or two
// - force selected byte bit to one
// - force selected byte bit to zero
// - invert selected byte bit
// - set/clear/invert/test: immediate or register bit
// - carry ANDed with bit
// - carry ANDed with inverted bit
// - carry ORed with bit
// - carry ORed with inverted bit
// - carry XORed with bit
// - carry XORed with inverted bit
// - bit copied into carry
// - inverted bit copied into carry
// - carry stored into selected bit
// - inverted carry stored into bit
// - inverted forms use immediate bit only
module shift_bit_unit (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire logic                 start,
    input  wire shift_bit_pkg::req_t  req,
    output logic                      busy,
    output logic                      done,
    output shift_bit_pkg::rsp_t       rsp
);
    import shift_bit_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic is_shift(input op_t o);
        is_shift = (o <= rotate_right_thru_carry);
    endfunction : is_shift

    function automatic logic imm_only(input op_t o);
        imm_only = (o == carry_and_inv_bit) || (o == carry_or_inv_bit)
                || (o == carry_xor_inv_bit) || (o == inv_bit_to_carry)
                || (o == inv_carry_to_bit);
    endfunction : imm_only

    function automatic logic reg_ok(input op_t o);
        reg_ok = (o == bit_force_one) || (o == bit_force_zero)
              || (o == bit_invert) || (o == bit_probe);
    endfunction : reg_ok

    state_t state_q;
    state_t state_d;
    req_t   req_q;
    rsp_t   rsp_q;
    rsp_t   rsp_d;
    logic   busy_q;
    logic   done_q;
    logic   step_q;

    ////////////////////////////////////////////////////////////////////////
    // datapath

    // register source only where permitted, else immediate
    wire       use_reg  = req_q.bitno_from_reg && reg_ok(req_q.op);
    wire       bad_src  = req_q.bitno_from_reg && imm_only(req_q.op);
    wire [2:0] bitno    = use_reg ? req_q.bitno_reg : req_q.bitno_imm;

    wire [31:0] sh_dout;
    wire        sh_cout;
    wire [7:0]  bu_dout;
    wire        bu_wr;
    wire        bu_cout;
    wire        bu_cwe;
    wire        bu_zout;
    wire        bu_zwe;

    // one position per cycle; two-position ops take two passes
    shift_stage u_shift (
        .din  (rsp_q.result),
        .cin  (rsp_q.carry),
        .op   (req_q.op),
        .size (req_q.size),
        .dout (sh_dout),
        .cout (sh_cout)
    );

    bit_unit u_bit (
        .din   (req_q.operand[7:0]),
        .bitno (bitno),
        .cin   (req_q.carry_in),
        .op    (req_q.op),
        .dout  (bu_dout),
        .wr    (bu_wr),
        .cout  (bu_cout),
        .c_we  (bu_cwe),
        .zout  (bu_zout),
        .z_we  (bu_zwe)
    );

    wire       shifting = is_shift(req_q.op);
    wire       last     = !req_q.two_pos || step_q;
    wire [31:0] bit_res = {req_q.operand[31:8], bu_dout};

    ////////////////////////////////////////////////////////////////////////
    // control

    always_comb begin
        state_d = state_q;
        rsp_d   = rsp_q;
        unique case (state_q)
            st_idle: if (start) begin
                state_d = st_busy;
            end
            st_busy: begin
                if (shifting) begin
                    rsp_d.result     = sh_dout;
                    rsp_d.carry      = sh_cout;
                    rsp_d.carry_we   = 1'b1;
                    rsp_d.write_back = 1'b1;
                    rsp_d.zero_we    = 1'b0;
                    rsp_d.bad_bitno_src = 1'b0;
                    if (last) begin
                        state_d = st_done;
                    end
                end else begin
                    // a refused register source leaves all state alone
                    rsp_d.result     = bit_res;
                    rsp_d.write_back = bu_wr && !bad_src;
                    rsp_d.carry      = bu_cout;
                    rsp_d.carry_we   = bu_cwe && !bad_src;
                    rsp_d.zero       = bu_zout;
                    rsp_d.zero_we    = bu_zwe;
                    rsp_d.bad_bitno_src = bad_src;
                    state_d = st_done;
                end
            end
            st_done: state_d = st_idle;
            default: state_d = st_idle;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q <= st_idle;
            req_q   <= '0;
            rsp_q   <= '0;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            step_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q  <= (state_d == st_busy);
            done_q  <= (state_q == st_busy) && (state_d == st_done);
            if (state_q == st_idle && start) begin
                req_q <= req;
                rsp_q <= '{result: req.operand, carry: req.carry_in,
                           default: 1'b0};
                step_q <= 1'b0;
            end else begin
                rsp_q  <= rsp_d;
                step_q <= (state_q == st_busy) ? 1'b1 : step_q;
            end
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign rsp  = rsp_q;

    ////////////////////////////////////////////////////////////////////////
    // checks

    wire [7:0] mask_c = 8'h01 << bitno;
    wire       sel_c  = req_q.operand[bitno];

    force_one_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_force_one && !bad_src)
        |=> (rsp.result[7:0] == ($past(req_q.operand[7:0]) | $past(mask_c)))
            && rsp.write_back && done)
        else $error("bit force one wrong");

    force_zero_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_force_zero)
        |=> (rsp.result[7:0] & $past(mask_c)) == 8'h00)
        else $error("bit force zero wrong");

    invert_bit_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_invert)
        |=> (rsp.result[7:0] ^ $past(req_q.operand[7:0])) == $past(mask_c))
        else $error("bit invert wrong");

    probe_zero_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_probe)
        |=> rsp.zero_we && !rsp.write_back && !rsp.carry_we
            && (rsp.zero == !$past(req_q.operand[bitno])))
        else $error("bit probe zero flag wrong");

    imm_only_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && imm_only(req_q.op) && req_q.bitno_from_reg)
        |=> !rsp.carry_we && !rsp.write_back && rsp.bad_bitno_src)
        else $error("register bit number accepted");

    carry_and_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == carry_and_bit)
        |=> rsp.carry == ($past(req_q.carry_in)
                          & $past(req_q.operand[bitno])) && rsp.carry_we)
        else $error("carry and bit wrong");

    store_carry_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == carry_to_bit)
        |=> rsp.result[$past(bitno)] == $past(req_q.carry_in)
            && !rsp.carry_we)
        else $error("carry to bit wrong");

    two_step_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_idle && start && is_shift(req.op) && req.two_pos)
        |=> busy ##1 busy ##1 done)
        else $error("two position shift timing wrong");

    one_step_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_idle && start && !req.two_pos)
        |=> busy ##1 done)
        else $error("single step timing wrong");

    shl_byte_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == logic_shift_left
         && req_q.size == size_byte && !req_q.two_pos)
        |=> rsp.result[7:0] == {$past(req_q.operand[6:0]), 1'b0}
            && rsp.carry == $past(req_q.operand[7]))
        else $error("byte logical shift left wrong");

    // req_q holds until the next take, so the done cycle may read it
    rot_byte_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == rotate_right
         && req_q.size == size_byte && !req_q.two_pos)
        |=> rsp.result[7:0] == {req_q.operand[0], req_q.operand[7:1]}
            && rsp.carry == req_q.operand[0])
        else $error("byte rotate right wrong");

    rotx_word_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == rotate_left_thru_carry
         && req_q.size == size_word && !req_q.two_pos)
        |=> rsp.result[15:0] == {req_q.operand[14:0], req_q.carry_in}
            && rsp.carry == req_q.operand[15])
        else $error("word rotate through carry wrong");

    rotate_left_two_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_idle && start && req.op == rotate_left
         && req.size == size_long && req.two_pos)
        |=> ##2 rsp.result == {req_q.operand[29:0], req_q.operand[31:30]}
            && rsp.carry == req_q.operand[30])
        else $error("two position rotate wrong");

    rotx_two_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_idle && start && req.op == rotate_right_thru_carry
         && req.size == size_byte && req.two_pos)
        |=> ##2 rsp.result[7:0] == {req_q.operand[0], req_q.carry_in,
                                    req_q.operand[7:2]}
            && rsp.carry == req_q.operand[1])
        else $error("two position carry rotate wrong");

    clear_we_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_force_zero)
        |=> rsp.write_back && !rsp.carry_we
            && rsp.result[7:0] == (req_q.operand[7:0] & ~mask_c))
        else $error("bit force zero write wrong");

    and_inv_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == carry_and_inv_bit && !bad_src)
        |=> rsp.carry_we && rsp.carry == (req_q.carry_in & !sel_c))
        else $error("carry and inverted bit wrong");

    or_bit_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == carry_or_bit)
        |=> rsp.carry_we && rsp.carry == (req_q.carry_in | sel_c))
        else $error("carry or bit wrong");

    or_inv_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == carry_or_inv_bit && !bad_src)
        |=> rsp.carry_we && rsp.carry == (req_q.carry_in | !sel_c))
        else $error("carry or inverted bit wrong");

    xor_inv_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == carry_xor_inv_bit && !bad_src)
        |=> rsp.carry_we && rsp.carry == (req_q.carry_in ^ !sel_c))
        else $error("carry xor inverted bit wrong");

    load_bit_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_to_carry)
        |=> rsp.carry_we && !rsp.write_back && rsp.carry == sel_c)
        else $error("bit to carry wrong");

    load_inv_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == inv_bit_to_carry && !bad_src)
        |=> rsp.carry_we && !rsp.write_back && rsp.carry == !sel_c)
        else $error("inverted bit to carry wrong");

    put_inv_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == inv_carry_to_bit && !bad_src)
        |=> rsp.write_back && !rsp.carry_we
            && rsp.result[bitno] == !req_q.carry_in)
        else $error("inverted carry to bit wrong");

    reg_bit_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && req_q.op == bit_invert && req_q.bitno_from_reg)
        |=> (rsp.result[7:0] ^ req_q.operand[7:0])
            == (8'h01 << req_q.bitno_reg))
        else $error("register bit number not used");

    keep_top_a: assert property (@(posedge clock) disable iff (!nrst)
        (state_q == st_busy && !shifting)
        |=> rsp.result[31:8] == req_q.operand[31:8]
            && !(rsp.zero_we && rsp.carry_we))
        else $error("bit op touched upper bytes");

    reset_out_a: assert property (@(posedge clock)
        !nrst |=> !busy && !done && rsp == '0)
        else $error("outputs not cleared by reset");

    done_one_a: assert property (@(posedge clock) disable iff (!nrst)
        done |=> !done)
        else $error("done longer than one cycle");

    shift_cv: cover property (@(posedge clock) disable iff (!nrst)
        done && req_q.op == rotate_left_thru_carry && req_q.two_pos);
    bitop_cv: cover property (@(posedge clock) disable iff (!nrst)
        done && req_q.op == bit_force_one && req_q.bitno_from_reg);
    carry_cv: cover property (@(posedge clock) disable iff (!nrst)
        done && req_q.op == carry_xor_inv_bit);
    probe_cv: cover property (@(posedge clock) disable iff (!nrst)
        done && req_q.op == bit_probe && rsp.zero);
    refuse_cv: cover property (@(posedge clock) disable iff (!nrst)
        done && rsp.bad_bitno_src);

endmodule : shift_bit_unit

`default_nettype wire

//--- test/shift_rotate_bit_manip_unit_bench.sv
/*
 * Self-checking bench for the shift/rotate and single-bit datapath.
 * Assumes shift_bit_pkg is compiled first; drives the unit's ports directly.
 */
`timescale 1ns/1ps
`default_nettype none

module shift_rotate_bit_manip_unit_bench;
    import shift_bit_pkg::*;

    logic        clock;
    logic        nrst;
    logic        start;
    req_t        req;
    logic        busy;
    logic        done;
    rsp_t        rsp;
    logic [15:0] rnd;
    int          bad_count;
    int          checked;

    shift_bit_unit shift_bit_unit_inst (
        .clock (clock),
        .nrst  (nrst),
        .start (start),
        .req   (req),
        .busy  (busy),
        .done  (done),
        .rsp   (rsp)
    );

    initial clock = 1'b0;
    always #12.5 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic next_word(output logic [31:0] w);
        rnd = lfsr(rnd);
        w[15:0] = rnd;
        rnd = lfsr(rnd);
        w[31:16] = rnd;
    endtask : next_word

    function automatic logic [31:0] mask_of(input req_t r);
        if (r.op > rotate_right_thru_carry || r.size == size_long)
            return 32'hffffffff;
        return (r.size == size_byte) ? 32'h000000ff : 32'h0000ffff;
    endfunction : mask_of

    // even opcodes of the shift group move left, odd ones right
    function automatic rsp_t model(input req_t r);
        rsp_t        e;
        logic [31:0] d;
        logic        c;
        logic        b;
        logic        s;
        logic        inv;
        logic [2:0]  n;
        int          w;
        e = '0;
        w = (r.size == size_byte) ? 8 : (r.size == size_word) ? 16 : 32;
        d = r.operand;
        c = r.carry_in;
        if (r.op <= rotate_right_thru_carry) begin
            d = d & mask_of(r);
            for (int k = 0; k < (r.two_pos ? 2 : 1); k++) begin
                b = r.op[0] ? d[0] : d[w-1];
                s = d[w-1];
                d = r.op[0] ? d >> 1 : d << 1;
                case (r.op)
                    arith_shift_right:       d[w-1] = s;
                    rotate_left:             d[0] = b;
                    rotate_right:            d[w-1] = b;
                    rotate_left_thru_carry:  d[0] = c;
                    rotate_right_thru_carry: d[w-1] = c;
                    default: ;
                endcase
                c = b;
            end
            e.result = d & mask_of(r);
            e.write_back = 1'b1;
            e.carry = c;
            e.carry_we = 1'b1;
            return e;
        end
        inv = r.op inside {carry_and_inv_bit, carry_or_inv_bit,
                           carry_xor_inv_bit, inv_bit_to_carry,
                           inv_carry_to_bit};
        n = (r.bitno_from_reg && r.op <= bit_probe) ? r.bitno_reg
                                                     : r.bitno_imm;
        b = d[n];
        if (inv && r.bitno_from_reg) begin
            e.bad_bitno_src = 1'b1;
            return e;
        end
        e.write_back = (r.op <= bit_invert) || (r.op >= carry_to_bit);
        e.carry_we = (r.op >= carry_and_bit) && (r.op <= inv_bit_to_carry);
        e.zero_we = (r.op == bit_probe);
        e.zero = ~b;
        case (r.op)
            bit_force_one:     d[n] = 1'b1;
            bit_force_zero:    d[n] = 1'b0;
            bit_invert:        d[n] = ~b;
            carry_and_bit:     c = c & b;
            carry_and_inv_bit: c = c & ~b;
            carry_or_bit:      c = c | b;
            carry_or_inv_bit:  c = c | ~b;
            carry_xor_bit:     c = c ^ b;
            carry_xor_inv_bit: c = c ^ ~b;
            bit_to_carry:      c = b;
            inv_bit_to_carry:  c = ~b;
            carry_to_bit:      d[n] = c;
            inv_carry_to_bit:  d[n] = ~c;
            default: ;
        endcase
        e.result = d;
        e.carry = c;
        return e;
    endfunction : model

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, what,
                     seen, exp);
        end
    endtask : check

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // pester keeps start high through busy, which must be ignored
    task automatic run_op(input req_t r, input logic pester);
        rsp_t e;
        int   n;
        int   lat;
        logic shf;
        logic lo;
        e = model(r);
        shf = (r.op <= rotate_right_thru_carry);
        lo = (r.op <= carry_or_inv_bit);
        lat = (shf && r.two_pos) ? 2 : 1;
        @(posedge clock);
        #2 start = 1'b1;
        req = r;
        @(posedge clock);
        #2 start = pester;
        n = 0;
        while (done !== 1'b1 && n < 6) begin
            check(busy, 1'b1, "busy");
            @(posedge clock);
            #1 n++;
        end
        #1 start = 1'b0;
        check(n, lat, "latency");
        check(rsp.bad_bitno_src, e.bad_bitno_src, "bad src");
        check(rsp.write_back, e.write_back, "write back");
        check(rsp.carry_we, e.carry_we, "carry we");
        check(rsp.zero_we, e.zero_we, "zero we");
        if (e.write_back && shf)
            check(rsp.result & mask_of(r), e.result, "sh");
        if (!shf && !e.bad_bitno_src)
            check(rsp.result, e.result, "bit");
        if (e.carry_we && shf)
            check(rsp.carry, e.carry, "sh c");
        if (e.carry_we && !shf && lo)
            check(rsp.carry, e.carry, "c");
        if (e.carry_we && !shf && !lo)
            check(rsp.carry, e.carry, "c");
        if (e.zero_we)
            check(rsp.zero, e.zero, "zero");
        @(posedge clock);
        #1 check({busy, done}, 2'b00, "after done");
    endtask : run_op

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    initial begin
        logic [31:0] w;
        logic [31:0] corner [4];
        req_t        r;
        int          k;
        corner = '{32'h80008081, 32'h00000000, 32'hffffffff, 32'h7fff7f7e};
        rnd = 16'h7864;
        bad_count = 0;
        checked = 0;
        nrst = 1'b0;
        start = 1'b0;
        req = '0;
        r = '0;
        repeat (12) @(posedge clock);
        #1 check(rsp.result, 32'h0, "reset result");
        check({busy, done, 24'h0, rsp[5:0]}, 32'h0, "reset flags");
        #1 nrst = 1'b1;
        // first pass sweeps every op, size, count and bit source
        for (int i = 0; i < 520; i++) begin
            next_word(w);
            r.operand = (i % 4 == 0) ? corner[(i / 4) % 4] : w;
            next_word(w);
            k = (i < 264) ? i : int'(w[15:0]);
            r.op = op_t'(k % 22);
            r.size = size_t'((k / 22) % 3);
            r.two_pos = 1'((k / 66) % 2);
            r.bitno_from_reg = 1'((k / 132) % 2);
            r.bitno_imm = w[18:16];
            r.bitno_reg = w[21:19];
            r.carry_in = w[22];
            run_op(r, w[23] & w[24]);
        end
        // reset while busy drops everything back to idle
        @(posedge clock);
        #2 start = 1'b1;
        @(posedge clock);
        #2 start = 1'b0;
        nrst = 1'b0;
        @(posedge clock);
        #1 check({busy, done, rsp.result[29:0]}, 32'h0, "mid reset");
        #1 nrst = 1'b1;
        run_op(r, 1'b0);
        print_verdict();
    end

endmodule : shift_rotate_bit_manip_unit_bench

`default_nettype wire
